// ---- verilog/aisd_regs.vh ----
// Purpose: Constants for the analog input scaling and diagnostic record block
// Assumes: 50 MHz core clock, byte-wide record reads
// Notes: Definitions only
`ifndef AISD_REGS_VH
`define AISD_REGS_VH

// Range codes
`define AISD_CODE_F27K_UNI 8'h10
`define AISD_CODE_F27K_BI 8'h12
`define AISD_CODE_F16K_UNI 8'h20
`define AISD_CODE_F16K_BI 8'h22
`define AISD_CODE_OFF 8'hFF

// Limits in the reported 16-bit format
`define AISD_F27K_HI 16'h7EFF
`define AISD_F27K_LO_BI 16'h8100
`define AISD_F27K_LO_UNI 16'hED00
`define AISD_F16K_HI 16'h5000
`define AISD_F16K_LO_BI 16'hB000
`define AISD_F16K_LO_UNI 16'hF333
// Raw converter code is 16384 per 10 V; 27648 format is raw * 27 / 16
`define AISD_F27K_MUL 22'h00001B
`define AISD_F27K_SHIFT 4

// Record access
`define AISD_MODE_SET 2'h0
`define AISD_MODE_INDEX 2'h1
`define AISD_MODE_SUB 2'h2
`define AISD_SET_HEAD 8'h00
`define AISD_SET_FULL 8'h01
`define AISD_INDEX_HEAD 16'h2F00
`define AISD_INDEX_FULL 16'h2F01
`define AISD_SUB_INDEX 16'h5005
`define AISD_SUB_FIRST 8'h02
`define AISD_SUB_LAST 8'h11
`define AISD_SUB_STAMP 8'h13
`define AISD_REC_HEAD_LEN 5'h04
`define AISD_REC_LEN 5'h14
`define AISD_REC_STAMP_OFS 5'h10

// Record byte offsets
`define AISD_B_SUMMARY 0
`define AISD_B_MODINFO 1
`define AISD_B_RSVD_C 2
`define AISD_B_INTERNAL 3
`define AISD_B_KIND 4
`define AISD_B_BITS 5
`define AISD_B_COUNT 6
`define AISD_B_GROUPS 7
`define AISD_B_CHAN0 8

// Constant bytes
`define AISD_MODULE_INFO 8'h15
`define AISD_CHANNEL_KIND 8'h71
`define AISD_BITS_PER_CHAN 8'h08
`define AISD_CHANNEL_COUNT 8'h04

// Field positions
`define AISD_SUM_MOD_FAIL 0
`define AISD_SUM_INT_ERR 1
`define AISD_SUM_EXT_ERR 2
`define AISD_SUM_CHAN_ERR 3
`define AISD_SUM_AUX_MISS 4
`define AISD_SUM_PARAM 7
`define AISD_INT_BUF_OVF 3
`define AISD_INT_COMM 4
`define AISD_CH_PARAM 0
`define AISD_CH_UNDER 6
`define AISD_CH_OVER 7

// Microsecond ticker
`define AISD_CLK_NS 20
`define AISD_US_NS 1000
`define AISD_US_CYC (`AISD_US_NS / `AISD_CLK_NS)
// Last divider count of one microsecond
`define AISD_US_LAST 6'h31

`endif

// ---- verilog/aisd_scale.v ----
// Purpose: Scale one raw conversion to the selected range format
// Assumes: Raw code is signed, 16384 counts per 10 V
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "aisd_regs.vh"

module aisd_scale (
	input wire [7:0] range_code,
	input wire [15:0] raw,
	output reg [15:0] value,
	output reg over,
	output reg under,
	output reg param_err,
	output reg chan_off
);

wire signed [21:0] raw_x = {{6{raw[15]}}, raw};
wire signed [21:0] f27k_prod = raw_x * $signed(`AISD_F27K_MUL);
wire signed [21:0] f27k_val = f27k_prod >>> `AISD_F27K_SHIFT;
reg signed [21:0] scaled;
reg signed [21:0] hi;
reg signed [21:0] lo;
reg [15:0] hi16;
reg [15:0] lo16;

always @* begin
	chan_off = 1'b0;
	param_err = 1'b0;
	scaled = raw_x;
	hi16 = `AISD_F16K_HI;
	lo16 = `AISD_F16K_LO_BI;
	case (range_code)
		`AISD_CODE_F27K_BI: begin
			scaled = f27k_val;
			hi16 = `AISD_F27K_HI;
			lo16 = `AISD_F27K_LO_BI;
		end
		`AISD_CODE_F27K_UNI: begin
			scaled = f27k_val;
			hi16 = `AISD_F27K_HI;
			lo16 = `AISD_F27K_LO_UNI;
		end
		`AISD_CODE_F16K_BI: begin
			scaled = raw_x;
		end
		`AISD_CODE_F16K_UNI: begin
			scaled = raw_x;
			lo16 = `AISD_F16K_LO_UNI;
		end
		`AISD_CODE_OFF: chan_off = 1'b1;
		default: param_err = 1'b1;
	endcase
	hi = {{6{hi16[15]}}, hi16};
	lo = {{6{lo16[15]}}, lo16};
	over = 1'b0;
	under = 1'b0;
	value = scaled[15:0];
	if (chan_off || param_err) begin
		value = 16'h0000;
	end else if (scaled > hi) begin
		over = 1'b1;
		value = hi16;
	end else if (scaled < lo) begin
		under = 1'b1;
		value = lo16;
	end
end

endmodule
`default_nettype wire

// ---- verilog/aisd_top.v ----
// Purpose: Digital side of a four-channel analog voltage input module
// Assumes: Conversions arrive from same-clock logic; coupler reads one byte per request
// Notes: Record is read only; no interrupt output exists
`timescale 1ns/1ps
`default_nettype none
`include "aisd_regs.vh"

module aisd_top (
	input wire core_clk,
	input wire rst_b,
	input wire [31:0] channel_range_code,
	input wire conv_valid,
	input wire [1:0] conv_chan,
	input wire [15:0] conv_data,
	input wire module_fail,
	input wire internal_err,
	input wire external_err,
	input wire aux_supply_ok_pin,
	input wire diag_buf_ovf,
	input wire int_comm_err,
	input wire rec_req,
	input wire [1:0] rec_mode,
	input wire [7:0] record_set_number,
	input wire [15:0] object_index,
	input wire [7:0] object_subindex,
	input wire [4:0] rec_byte,
	output reg [15:0] meas_value_r,
	output reg [1:0] meas_chan_r,
	output reg meas_valid_r,
	output reg [3:0] chan_led_r,
	output reg rec_ack_r,
	output reg [7:0] rec_data_r,
	output reg rec_err_r
);

////////////////////////////////////////////////////////////////////////////////
// Range code checks

function param_bad;
	input [7:0] code;
	begin
		case (code)
			`AISD_CODE_F27K_UNI, `AISD_CODE_F27K_BI,
			`AISD_CODE_F16K_UNI, `AISD_CODE_F16K_BI,
			`AISD_CODE_OFF: param_bad = 1'b0;
			default: param_bad = 1'b1;
		endcase
	end
endfunction

wire [3:0] chan_off;
wire [3:0] chan_param;
genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_code
		assign chan_off[gi] = (channel_range_code[gi*8 +: 8] == `AISD_CODE_OFF);
		assign chan_param[gi] = param_bad(channel_range_code[gi*8 +: 8]);
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Pin synchroniser

reg aux_meta_r;
reg aux_sync_r;

always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		aux_meta_r <= 1'b1;
		aux_sync_r <= 1'b1;
	end else begin
		aux_meta_r <= aux_supply_ok_pin;
		aux_sync_r <= aux_meta_r;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Conversion scaling

wire [7:0] sel_code = channel_range_code[conv_chan*8 +: 8];
wire [15:0] sc_value;
wire sc_over;
wire sc_under;
wire sc_param;
wire sc_off;

aisd_scale u_scale (
	.range_code(sel_code),
	.raw(conv_data),
	.value(sc_value),
	.over(sc_over),
	.under(sc_under),
	.param_err(sc_param),
	.chan_off(sc_off)
);

reg [3:0] over_r;
reg [3:0] under_r;

always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		meas_value_r <= 16'h0000;
		meas_chan_r <= 2'h0;
		meas_valid_r <= 1'b0;
	end else begin
		meas_valid_r <= 1'b0;
		if (conv_valid && !sc_off && !sc_param) begin
			meas_value_r <= sc_value;
			meas_chan_r <= conv_chan;
			meas_valid_r <= 1'b1;
		end
	end
end

// Range flags follow the latest conversion of each channel
always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		over_r <= 4'h0;
		under_r <= 4'h0;
	end else begin
		// Latest result of the converted channel; off channels forced clear
		over_r <= (conv_valid ? (over_r & ~(4'h1 << conv_chan)) |
			({3'h0, sc_over} << conv_chan) : over_r) & ~chan_off;
		under_r <= (conv_valid ? (under_r & ~(4'h1 << conv_chan)) |
			({3'h0, sc_under} << conv_chan) : under_r) & ~chan_off;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Diagnostic bytes

wire [7:0] chan_byte [0:3];
wire [3:0] group_err;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
		assign chan_byte[gi] = {over_r[gi], under_r[gi], 5'h00, chan_param[gi]};
		assign group_err[gi] = |chan_byte[gi];
	end
endgenerate

wire [7:0] group_byte = {4'h0, group_err};
wire [7:0] summary_byte;
assign summary_byte[`AISD_SUM_MOD_FAIL] = module_fail;
assign summary_byte[`AISD_SUM_INT_ERR] = internal_err;
assign summary_byte[`AISD_SUM_EXT_ERR] = external_err;
assign summary_byte[`AISD_SUM_CHAN_ERR] = |group_err;
assign summary_byte[`AISD_SUM_AUX_MISS] = ~aux_sync_r;
assign summary_byte[6:5] = 2'h0;
assign summary_byte[`AISD_SUM_PARAM] = |chan_param;
wire [7:0] internal_byte = {3'h0, int_comm_err, diag_buf_ovf, 3'h0};

// Registered record image; reads and event detection share it
reg [7:0] summary_r;
reg [7:0] internal_r;
reg [7:0] groups_r;
reg [31:0] chan_bytes_r;
wire [31:0] chan_bytes_nxt = {chan_byte[3], chan_byte[2], chan_byte[1], chan_byte[0]};

always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		summary_r <= 8'h00;
		internal_r <= 8'h00;
		groups_r <= 8'h00;
		chan_bytes_r <= 32'h00000000;
	end else begin
		summary_r <= summary_byte;
		internal_r <= internal_byte;
		groups_r <= group_byte;
		chan_bytes_r <= chan_bytes_nxt;
	end
end

// Indicators: off for deactivated channels
always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		chan_led_r <= 4'h0;
	end else begin
		chan_led_r <= group_err & ~chan_off;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Microsecond ticker and event stamp

reg [5:0] us_div_r;
reg [31:0] us_cnt_r;
reg [31:0] stamp_r;
wire us_tick = (us_div_r == `AISD_US_LAST);
wire diag_event = (summary_byte != summary_r) || (internal_byte != internal_r) ||
	(chan_bytes_nxt != chan_bytes_r);

always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		us_div_r <= 6'h00;
		us_cnt_r <= 32'h00000000;
		stamp_r <= 32'h00000000;
	end else begin
		us_div_r <= us_tick ? 6'h00 : us_div_r + 6'h01;
		if (us_tick) begin
			us_cnt_r <= us_cnt_r + 32'h00000001;
		end
		if (diag_event) begin
			stamp_r <= us_cnt_r;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Record read port

reg [7:0] rec_image [0:19];
integer k;

always @* begin
	rec_image[`AISD_B_SUMMARY] = summary_r;
	rec_image[`AISD_B_MODINFO] = `AISD_MODULE_INFO;
	rec_image[`AISD_B_RSVD_C] = 8'h00;
	rec_image[`AISD_B_INTERNAL] = internal_r;
	rec_image[`AISD_B_KIND] = `AISD_CHANNEL_KIND;
	rec_image[`AISD_B_BITS] = `AISD_BITS_PER_CHAN;
	rec_image[`AISD_B_COUNT] = `AISD_CHANNEL_COUNT;
	rec_image[`AISD_B_GROUPS] = groups_r;
	for (k = 0; k < 4; k = k + 1) begin
		rec_image[`AISD_B_CHAN0 + k] = chan_bytes_r[k*8 +: 8];
		rec_image[12 + k] = 8'h00;
		rec_image[16 + k] = stamp_r[k*8 +: 8];
	end
end

reg [4:0] rd_ofs;
reg rd_bad;
reg [4:0] sub_ofs;
wire [7:0] sub_diff = object_subindex - `AISD_SUB_FIRST;

always @* begin
	rd_ofs = rec_byte;
	rd_bad = 1'b0;
	sub_ofs = sub_diff[4:0];
	case (rec_mode)
		`AISD_MODE_SET: begin
			if (record_set_number == `AISD_SET_FULL) begin
				rd_bad = (rec_byte >= `AISD_REC_LEN);
			end else if (record_set_number == `AISD_SET_HEAD) begin
				rd_bad = (rec_byte >= `AISD_REC_HEAD_LEN);
			end else begin
				rd_bad = 1'b1;
			end
		end
		`AISD_MODE_INDEX: begin
			if (object_index == `AISD_INDEX_FULL) begin
				rd_bad = (rec_byte >= `AISD_REC_LEN);
			end else if (object_index == `AISD_INDEX_HEAD) begin
				rd_bad = (rec_byte >= `AISD_REC_HEAD_LEN);
			end else begin
				rd_bad = 1'b1;
			end
		end
		`AISD_MODE_SUB: begin
			if (object_index != `AISD_SUB_INDEX) begin
				rd_bad = 1'b1;
			end else if (object_subindex >= `AISD_SUB_FIRST &&
				object_subindex <= `AISD_SUB_LAST) begin
				rd_ofs = sub_ofs;
			end else if (object_subindex == `AISD_SUB_STAMP) begin
				rd_ofs = `AISD_REC_STAMP_OFS + {3'h0, rec_byte[1:0]};
			end else begin
				rd_bad = 1'b1;
			end
		end
		default: rd_bad = 1'b1;
	endcase
end

always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		rec_ack_r <= 1'b0;
		rec_data_r <= 8'h00;
		rec_err_r <= 1'b0;
	end else begin
		rec_ack_r <= rec_req;
		rec_err_r <= rec_req && rd_bad;
		if (rec_req) begin
			rec_data_r <= rd_bad ? 8'h00 : rec_image[rd_ofs];
		end
	end
end

endmodule
`default_nettype wire

// ---- bench/aisd_top_props.sv ----
// Purpose: Port checker for the analog input block
// Assumes: One clock, reset active low
// Notes: Attached by bind
`timescale 1ns/1ps
`default_nettype none
module aisd_top_props (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [31:0] channel_range_code,
	input wire logic conv_valid,
	input wire logic [1:0] conv_chan,
	input wire logic [15:0] conv_data,
	input wire logic rec_req,
	input wire logic [1:0] rec_mode,
	input wire logic [7:0] record_set_number,
	input wire logic [15:0] object_index,
	input wire logic [7:0] object_subindex,
	input wire logic [4:0] rec_byte,
	input wire logic [15:0] meas_value_r,
	input wire logic [1:0] meas_chan_r,
	input wire logic meas_valid_r,
	input wire logic [3:0] chan_led_r,
	input wire logic rec_ack_r,
	input wire logic [7:0] rec_data_r,
	input wire logic rec_err_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic [7:0] cur_code;
	assign cur_code = 8'(channel_range_code >> {conv_chan, 3'b000});
	ack_next_a: assert property (rec_req |=> rec_ack_r)
		else $error("read not acknowledged");
	ack_only_a: assert property (!rec_req |=> !rec_ack_r)
		else $error("acknowledge without read");
	mode_refuse_a: assert property (rec_req && rec_mode == 2'h3 |=> rec_err_r && rec_data_r == 8'h00)
		else $error("bad mode not refused");
	head_len_a: assert property (rec_req && rec_mode == 2'h0 && record_set_number == 8'h00
		&& rec_byte > 5'h03 |=> rec_err_r) else $error("head read too long");
	index_full_a: assert property (rec_req && rec_mode == 2'h1 && object_index == 16'h2F01
		&& rec_byte == 5'h01 |=> !rec_err_r && rec_data_r == 8'h15) else $error("module info wrong");
	sub_kind_a: assert property (rec_req && rec_mode == 2'h2 && object_index == 16'h5005
		&& object_subindex == 8'h06 |=> rec_data_r == 8'h71) else $error("channel kind wrong");
	off_quiet_a: assert property (conv_valid && cur_code == 8'hFF |=> !meas_valid_r)
		else $error("off channel measured");
	plain_scale_a: assert property (conv_valid && cur_code == 8'h22
		&& $signed(conv_data) <= 20480 && $signed(conv_data) >= -20480
		|=> meas_valid_r && meas_value_r == $past(conv_data) && meas_chan_r == $past(conv_chan))
		else $error("16384 format value wrong");
	off_led_a: assert property (channel_range_code[7:0] == 8'hFF [*3] |-> !chan_led_r[0])
		else $error("off channel indicator lit");
endmodule
bind aisd_top aisd_top_props u_aisd_top_props (.core_clk, .rst_b, .channel_range_code,
	.conv_valid, .conv_chan, .conv_data, .rec_req, .rec_mode, .record_set_number,
	.object_index, .object_subindex, .rec_byte, .meas_value_r, .meas_chan_r,
	.meas_valid_r, .chan_led_r, .rec_ack_r, .rec_data_r, .rec_err_r);
`default_nettype wire

// ---- bench/aisd_coupler.sv ----
// Purpose: Bus coupler model reading the diagnostic record
// Assumes: One byte per request, answer one cycle later
// Notes: Idle address lines show inverted values
`timescale 1ns/1ps
`default_nettype none
module aisd_coupler (
	input wire logic core_clk,
	output logic rec_req,
	output logic [1:0] rec_mode,
	output logic [7:0] record_set_number,
	output logic [15:0] object_index,
	output logic [7:0] object_subindex,
	output logic [4:0] rec_byte,
	input wire logic rec_ack_r,
	input wire logic [7:0] rec_data_r,
	input wire logic rec_err_r
);
	initial begin
		rec_req = 1'b0;
		{rec_mode, record_set_number, object_index, object_subindex, rec_byte} = '0;
	end
	task automatic rd(input logic [1:0] m, input logic [7:0] n, input logic [15:0] ix,
		input logic [7:0] sx, input logic [4:0] b, output logic [9:0] r);
		@(negedge core_clk);
		rec_req = 1'b1;
		{rec_mode, record_set_number, object_index, object_subindex, rec_byte} = {m, n, ix, sx, b};
		@(negedge core_clk);
		rec_req = 1'b0;
		{rec_mode, record_set_number, object_index, object_subindex, rec_byte} = ~{m, n, ix, sx, b};
		r = {rec_ack_r, rec_err_r, rec_data_r};
	endtask
endmodule
`default_nettype wire

// ---- bench/aisd_top_tb_top.sv ----
// Purpose: Self-checking bench for the analog input block
// Assumes: Coupler model issues record reads
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module aisd_top_tb_top;
	logic core_clk, rst_b, conv_valid, module_fail, internal_err, external_err, aux_supply_ok_pin;
	logic diag_buf_ovf, int_comm_err, rec_req, rec_ack_r, rec_err_r, meas_valid_r;
	logic [31:0] channel_range_code;
	logic [1:0] conv_chan, rec_mode, meas_chan_r;
	logic [15:0] conv_data, object_index, meas_value_r;
	logic [7:0] record_set_number, object_subindex, rec_data_r;
	logic [4:0] rec_byte;
	logic [3:0] chan_led_r;
	logic [9:0] r;
	int num_errors = 0;
	int cmp_count = 0;
	aisd_top u_aisd_top (.core_clk, .rst_b, .channel_range_code, .conv_valid, .conv_chan,
		.conv_data, .module_fail, .internal_err, .external_err, .aux_supply_ok_pin,
		.diag_buf_ovf, .int_comm_err, .rec_req, .rec_mode, .record_set_number, .object_index,
		.object_subindex, .rec_byte, .meas_value_r, .meas_chan_r, .meas_valid_r, .chan_led_r,
		.rec_ack_r, .rec_data_r, .rec_err_r);
	aisd_coupler u_aisd_coupler (.core_clk, .rec_req, .rec_mode, .record_set_number,
		.object_index, .object_subindex, .rec_byte, .rec_ack_r, .rec_data_r, .rec_err_r);
	////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rdc(input string n, input logic [1:0] m, input logic [15:0] ix,
		input logic [7:0] a, input logic [4:0] b, input logic [9:0] e);
		u_aisd_coupler.rd(m, a, ix, a, b, r);
		chk(n, {6'h0, r}, {6'h0, e});
	endtask
	task automatic cv(input logic [1:0] c, input logic [15:0] d);
		@(negedge core_clk);
		conv_valid = 1'b1;
		conv_chan = c;
		conv_data = d;
		@(negedge core_clk);
		conv_valid = 1'b0;
		conv_data = ~d;
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_consts;
		logic [7:0] eb [16] = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h71, 8'h08, 8'h04, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 16; i++)
			rdc("sub_byte", 2'h2, 16'h5005, 8'(i + 2), 5'h0, {2'b10, eb[i]});
		rdc("set_full", 2'h0, 16'h0, 8'h01, 5'h01, 10'h215);
		rdc("set_head", 2'h0, 16'h0, 8'h00, 5'h04, 10'h300);
		rdc("index_head", 2'h1, 16'h2F00, 8'h0, 5'h04, 10'h300);
		rdc("index_full", 2'h1, 16'h2F01, 8'h0, 5'h06, 10'h204);
		rdc("sub_gap", 2'h2, 16'h5005, 8'h12, 5'h0, 10'h300);
		rdc("mode3", 2'h3, 16'h0, 8'h0, 5'h0, 10'h300);
		$display("t_consts done");
	endtask
	task automatic t_scale;
		logic [39:0] t [11] = '{{8'h12, 32'h40006C00}, {8'h12, 32'hC0009400},
			{8'h12, 32'h7FFF7EFF}, {8'h12, 32'h80008100}, {8'h10, 32'hE000ED00},
			{8'h10, 32'h20003600}, {8'h22, 32'h70005000}, {8'h22, 32'h9000B000},
			{8'h22, 32'hC000C000}, {8'h20, 32'hC000F333}, {8'h22, 32'h40004000}};
		foreach (t[i]) begin
			@(negedge core_clk);
			channel_range_code[15:8] = t[i][39:32];
			cv(2'h1, t[i][31:16]);
			chk("meas_value", meas_value_r, t[i][15:0]);
			chk("meas_tag", {13'h0, meas_valid_r, meas_chan_r}, 16'h0005);
		end
		$display("t_scale done");
	endtask
	task automatic t_errors;
		cv(2'h0, 16'h7FFF);
		repeat (2) @(negedge core_clk);
		chk("led_over", {12'h0, chan_led_r}, 16'h0001);
		rdc("ch0_over", 2'h2, 16'h5005, 8'h0A, 5'h0, 10'h280);
		rdc("groups", 2'h2, 16'h5005, 8'h09, 5'h0, 10'h201);
		rdc("summary", 2'h2, 16'h5005, 8'h02, 5'h0, 10'h208);
		cv(2'h0, 16'h8000);
		repeat (2) @(negedge core_clk);
		rdc("ch0_under", 2'h2, 16'h5005, 8'h0A, 5'h0, 10'h240);
		channel_range_code[31:24] = 8'h33;
		repeat (3) @(negedge core_clk);
		rdc("ch3_param", 2'h2, 16'h5005, 8'h0D, 5'h0, 10'h201);
		rdc("summary_p", 2'h2, 16'h5005, 8'h02, 5'h0, 10'h288);
		rdc("groups_p", 2'h2, 16'h5005, 8'h09, 5'h0, 10'h209);
		channel_range_code[7:0] = 8'hFF;
		cv(2'h0, 16'h7FFF);
		chk("off_meas", {15'h0, meas_valid_r}, 16'h0);
		repeat (2) @(negedge core_clk);
		chk("led_off", {12'h0, chan_led_r}, 16'h0008);
		rdc("ch0_off", 2'h2, 16'h5005, 8'h0A, 5'h0, 10'h200);
		channel_range_code = 32'h12121212;
		cv(2'h0, 16'h0);
		repeat (3) @(negedge core_clk);
		rdc("summary_clr", 2'h2, 16'h5005, 8'h02, 5'h0, 10'h200);
		$display("t_errors done");
	endtask
	task automatic t_status;
		logic [31:0] st;
		{module_fail, internal_err, external_err, diag_buf_ovf, int_comm_err} = 5'h1F;
		aux_supply_ok_pin = 1'b0;
		repeat (5) @(negedge core_clk);
		rdc("sum_status", 2'h0, 16'h0, 8'h00, 5'h00, 10'h217);
		rdc("internal", 2'h1, 16'h2F00, 8'h0, 5'h03, 10'h218);
		for (int i = 0; i < 4; i++) begin
			u_aisd_coupler.rd(2'h2, 8'h13, 16'h5005, 8'h13, 5'(i), r);
			st[8*i +: 8] = r[7:0];
		end
		chk("stamp", {15'h0, st != 0 && st < 100}, 16'h1);
		{module_fail, internal_err, external_err, diag_buf_ovf, int_comm_err} = 5'h0;
		aux_supply_ok_pin = 1'b1;
		repeat (5) @(negedge core_clk);
		rdc("sum_clear", 2'h0, 16'h0, 8'h01, 5'h00, 10'h200);
		$display("t_status done");
	endtask
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		num_errors++;
		conclude();
	end
	initial begin
		rst_b = 1'b0;
		{conv_valid, conv_chan, conv_data, module_fail, internal_err, external_err} = '0;
		{diag_buf_ovf, int_comm_err} = 2'h0;
		aux_supply_ok_pin = 1'b1;
		channel_range_code = 32'h12121212;
		repeat (2) @(negedge core_clk);
		rst_b = 1'b1;
		t_consts();
		t_scale();
		t_errors();
		t_status();
		conclude();
	end
endmodule
`default_nettype wire
